// File: sfl_consts.svh
`ifndef SFL_CONSTS_SVH
`define SFL_CONSTS_SVH
// ==============================
// Opcodes
`define SFL_OP_WREN 8'h06
`define SFL_OP_RD_EXT 8'hc8
`define SFL_OP_WR_EXT 8'hc5
`define SFL_OP_EN4 8'hb7
`define SFL_OP_EX4 8'he9
`define SFL_OP_READ 8'h03
`define SFL_OP_READ4 8'h13
`define SFL_OP_FAST 8'h0b
`define SFL_OP_FAST4 8'h0c
`define SFL_OP_DUAL 8'h3b
`define SFL_OP_DUAL4 8'h3c
`define SFL_OP_QUAD 8'h6b
// ==============================
// Frame bit and dummy cycle counts
`define SFL_TXN_A4 6'h28
`define SFL_TXN_A3 6'h20
`define SFL_TXN_WR 6'h10
`define SFL_TXN_OP 6'h08
`define SFL_DUMMY_CYC 4'h8
// ==============================
// Timing
`define SFL_CORE_MHZ 200
`define SFL_SLOW_READ_MHZ 50
`define SFL_SLOW_HALF ((`SFL_CORE_MHZ + 2 * `SFL_SLOW_READ_MHZ - 1) / (2 * `SFL_SLOW_READ_MHZ))
`define SFL_HALF_DEF 4
// ==============================
// Reset values
`define SFL_EXT_RST 8'h00
`define SFL_MODE_RST 1'b0
`define SFL_OE_N_RST 4'h2
`endif

// File: sfl_pkg.sv
`include "sfl_consts.svh"
package sfl_pkg;
   typedef enum logic [4:0] {
      PH_IDLE = 5'b00001,
      PH_TX = 5'b00010,
      PH_DUMMY = 5'b00100,
      PH_RX = 5'b01000,
      PH_END = 5'b10000
   } sfl_phase_t;

   typedef enum logic [5:0] {
      SQ_IDLE = 6'b000001,
      SQ_PRE_WE = 6'b000010,
      SQ_MAIN = 6'b000100,
      SQ_CHK = 6'b001000,
      SQ_FIX_WE = 6'b010000,
      SQ_FIX_WR = 6'b100000
   } sfl_seq_t;

   typedef struct packed {
      logic known;
      logic has_addr;
      logic force32;
      logic has_wr;
      logic dummy;
      logic [2:0] lanes;
      logic slow;
   } sfl_dec_t;

   function automatic sfl_dec_t sfl_decode(input logic [7:0] op);
      sfl_dec_t d;
      d = '0;
      d.known = 1'b1;
      case (op)
         `SFL_OP_WREN, `SFL_OP_EN4, `SFL_OP_EX4: d.known = 1'b1;
         `SFL_OP_WR_EXT: d.has_wr = 1'b1;
         `SFL_OP_RD_EXT: d.lanes = 3'h1;
         `SFL_OP_READ, `SFL_OP_READ4: begin
            d.has_addr = 1'b1;
            d.force32 = (op == `SFL_OP_READ4);
            d.lanes = 3'h1;
            d.slow = 1'b1;
         end
         `SFL_OP_FAST, `SFL_OP_FAST4: begin
            d.has_addr = 1'b1;
            d.force32 = (op == `SFL_OP_FAST4);
            d.dummy = 1'b1;
            d.lanes = 3'h1;
         end
         `SFL_OP_DUAL, `SFL_OP_DUAL4: begin
            d.has_addr = 1'b1;
            d.force32 = (op == `SFL_OP_DUAL4);
            d.dummy = 1'b1;
            d.lanes = 3'h2;
         end
         `SFL_OP_QUAD: begin
            d.has_addr = 1'b1;
            d.dummy = 1'b1;
            d.lanes = 3'h4;
         end
         default: d.known = 1'b0;
      endcase
      return d;
   endfunction
endpackage

// File: sfl_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfl_consts.svh"
module sfl_host
   import sfl_pkg::*;
#(
   parameter int P_HALF = `SFL_HALF_DEF,
   parameter int P_LEN_W = 16
) (
   input wire logic i_core_clk, // Core clock
   input wire logic i_rst, // Sync reset, high
   input wire logic i_cmd_valid, // Command request
   input wire logic [7:0] i_cmd_opcode, // Flash opcode
   input wire logic [31:0] i_cmd_addr, // Array address
   input wire logic [7:0] i_cmd_wdata, // Upper byte to write
   input wire logic [P_LEN_W-1:0] i_cmd_len, // Bytes to read
   output logic o_cmd_ready, // Idle, takes command
   output logic o_busy, // Sequence running
   output logic o_rd_valid, // Read byte strobe
   output logic [7:0] o_rd_data, // Read byte
   output logic o_addr_mode32, // Host view of size flag
   output logic o_sck, // Serial clock
   output logic o_cs_n, // Chip select, low active
   output logic [3:0] o_io_out, // Lane drive values
   output logic [3:0] o_io_oe_n, // Lane enables, low drives
   input wire logic [3:0] i_io_in // Lane pin levels
);
   localparam int LP_SLOW_HALF = `SFL_SLOW_HALF;
   localparam int LP_HALF_SLOW = (P_HALF > LP_SLOW_HALF) ? P_HALF : LP_SLOW_HALF;

   function automatic logic [3:0] sfl_slots(input logic [2:0] l);
      case (l)
         3'h2: return 4'h4;
         3'h4: return 4'h2;
         default: return 4'h8;
      endcase
   endfunction

   // ==============================
   // Pin input synchroniser
   logic [3:0] io_s1_ff, io_s2_ff, io_s3_ff, io_q_ff, io_q_nxt;
   assign io_q_nxt = (io_s2_ff & io_s3_ff) | (io_q_ff & (io_s2_ff | io_s3_ff));
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         io_s1_ff <= 4'h0;
         io_s2_ff <= 4'h0;
         io_s3_ff <= 4'h0;
         io_q_ff <= 4'h0;
      end else begin
         io_s1_ff <= i_io_in;
         io_s2_ff <= io_s1_ff;
         io_s3_ff <= io_s2_ff;
         io_q_ff <= io_q_nxt;
      end
   end

   // ==============================
   // Registers
   sfl_seq_t seq_ff;
   sfl_phase_t ph_ff;
   logic issued_ff, mode32_ff, done_ff, rd_valid_ff;
   logic [7:0] op_ff, wdata_ff, ext_user_ff, fop_ff, rd_data_ff, rx_sr_ff;
   logic [31:0] addr_ff;
   logic [P_LEN_W-1:0] len_ff, rlen_ff;
   logic sck_ff, cs_n_ff, dummy_ff;
   logic [47:0] tx_sr_ff;
   logic [5:0] cnt_ff;
   logic [2:0] lanes_ff;
   logic [3:0] bitc_ff, oe_n_ff;
   logic [7:0] half_ff, hcnt_ff;

   // ==============================
   // Frame descriptor
   logic [7:0] fr_op, fr_wd;
   sfl_dec_t fr_dec, cmd_dec;
   logic [47:0] fr_tx;
   logic [5:0] fr_txn;
   logic [P_LEN_W-1:0] fr_len;
   logic req_go;
   logic [7:0] nxt_rx;

   assign cmd_dec = sfl_decode(i_cmd_opcode);
   assign req_go = (seq_ff != SQ_IDLE) && !issued_ff && (ph_ff == PH_IDLE);

   always_comb begin
      fr_op = op_ff;
      fr_wd = wdata_ff;
      case (seq_ff)
         SQ_PRE_WE, SQ_FIX_WE: fr_op = `SFL_OP_WREN;
         SQ_CHK: fr_op = `SFL_OP_RD_EXT;
         SQ_FIX_WR: begin
            fr_op = `SFL_OP_WR_EXT;
            fr_wd = ext_user_ff;
         end
         default: fr_op = op_ff;
      endcase
      fr_dec = sfl_decode(fr_op);
      fr_len = (seq_ff == SQ_MAIN) ? len_ff : P_LEN_W'(1);
      if (fr_dec.has_addr && (mode32_ff || fr_dec.force32)) begin
         fr_tx = {fr_op, addr_ff, 8'h00};
         fr_txn = `SFL_TXN_A4;
      end else if (fr_dec.has_addr) begin
         fr_tx = {fr_op, addr_ff[23:0], 16'h0000};
         fr_txn = `SFL_TXN_A3;
      end else if (fr_dec.has_wr) begin
         fr_tx = {fr_op, fr_wd, 32'h0000_0000};
         fr_txn = `SFL_TXN_WR;
      end else begin
         fr_tx = {fr_op, 40'h00_0000_0000};
         fr_txn = `SFL_TXN_OP;
      end
   end

   // Upper nibble first on quad, lane 1 first on dual
   always_comb begin
      case (lanes_ff)
         3'h2: nxt_rx = {rx_sr_ff[5:0], io_q_nxt[1], io_q_nxt[0]};
         3'h4: nxt_rx = {rx_sr_ff[3:0], io_q_nxt};
         default: nxt_rx = {rx_sr_ff[6:0], io_q_nxt[1]};
      endcase
   end

   // ==============================
   // Command sequencer
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         seq_ff <= SQ_IDLE;
         issued_ff <= 1'b0;
         op_ff <= 8'h00;
         addr_ff <= 32'h0000_0000;
         wdata_ff <= 8'h00;
         len_ff <= '0;
         ext_user_ff <= `SFL_EXT_RST;
         mode32_ff <= `SFL_MODE_RST;
      end else begin
         case (seq_ff)
            SQ_IDLE: begin
               if (i_cmd_valid && cmd_dec.known) begin
                  op_ff <= i_cmd_opcode;
                  addr_ff <= i_cmd_addr;
                  wdata_ff <= i_cmd_wdata;
                  len_ff <= (i_cmd_len == '0) ? P_LEN_W'(1) : i_cmd_len;
                  if (i_cmd_opcode == `SFL_OP_WR_EXT) begin
                     ext_user_ff <= i_cmd_wdata;
                     seq_ff <= SQ_PRE_WE;
                  end else begin
                     seq_ff <= SQ_MAIN;
                  end
               end
            end
            default: begin
               if (req_go) begin
                  issued_ff <= 1'b1;
               end
               if (done_ff) begin
                  issued_ff <= 1'b0;
                  case (seq_ff)
                     SQ_PRE_WE: seq_ff <= SQ_MAIN;
                     SQ_MAIN: begin
                        if (op_ff == `SFL_OP_EN4) begin
                           mode32_ff <= 1'b1;
                        end
                        if (op_ff == `SFL_OP_EX4) begin
                           mode32_ff <= 1'b0;
                           seq_ff <= SQ_CHK;
                        end else begin
                           seq_ff <= SQ_IDLE;
                        end
                     end
                     SQ_CHK: seq_ff <= (rd_data_ff != ext_user_ff) ? SQ_FIX_WE : SQ_IDLE;
                     SQ_FIX_WE: seq_ff <= SQ_FIX_WR;
                     default: seq_ff <= SQ_IDLE;
                  endcase
               end
            end
         endcase
      end
   end

   // ==============================
   // Serial frame engine
   always_ff @(posedge i_core_clk) begin
      rd_valid_ff <= 1'b0;
      done_ff <= 1'b0;
      if (i_rst) begin
         ph_ff <= PH_IDLE;
         sck_ff <= 1'b0;
         cs_n_ff <= 1'b1;
         tx_sr_ff <= '0;
         cnt_ff <= 6'h00;
         dummy_ff <= 1'b0;
         lanes_ff <= 3'h0;
         rlen_ff <= '0;
         bitc_ff <= 4'h0;
         rx_sr_ff <= 8'h00;
         rd_data_ff <= 8'h00;
         oe_n_ff <= `SFL_OE_N_RST;
         half_ff <= 8'h00;
         hcnt_ff <= 8'h00;
         fop_ff <= 8'h00;
      end else begin
         case (ph_ff)
            PH_IDLE: begin
               if (req_go) begin
                  ph_ff <= PH_TX;
                  cs_n_ff <= 1'b0;
                  sck_ff <= 1'b0;
                  tx_sr_ff <= fr_tx;
                  cnt_ff <= fr_txn;
                  dummy_ff <= fr_dec.dummy;
                  lanes_ff <= fr_dec.lanes;
                  rlen_ff <= fr_len;
                  fop_ff <= fr_op;
                  oe_n_ff <= {{2{fr_dec.lanes == 3'h4}}, 2'b10};
                  half_ff <= fr_dec.slow ? 8'(LP_HALF_SLOW) : 8'(P_HALF);
                  hcnt_ff <= fr_dec.slow ? 8'(LP_HALF_SLOW - 1) : 8'(P_HALF - 1);
               end
            end
            default: begin
               // Release one cycle after the last address rise, clear of the sample
               if (ph_ff == PH_DUMMY || ph_ff == PH_RX) begin
                  oe_n_ff[0] <= 1'b1;
               end
               if (hcnt_ff != 8'h00) begin
                  hcnt_ff <= hcnt_ff - 8'h01;
               end else begin
                  hcnt_ff <= half_ff - 8'h01;
                  if (ph_ff == PH_END && !sck_ff) begin
                     if (!cs_n_ff) begin
                        cs_n_ff <= 1'b1;
                     end else begin
                        ph_ff <= PH_IDLE;
                        done_ff <= 1'b1;
                        oe_n_ff <= `SFL_OE_N_RST;
                     end
                  end else if (sck_ff) begin
                     sck_ff <= 1'b0;
                     if (ph_ff == PH_TX) begin
                        tx_sr_ff <= {tx_sr_ff[46:0], 1'b0};
                     end
                  end else begin
                     sck_ff <= 1'b1;
                     case (ph_ff)
                        PH_TX: begin
                           if (cnt_ff == 6'h01) begin
                              if (dummy_ff) begin
                                 ph_ff <= PH_DUMMY;
                                 cnt_ff <= {2'b00, `SFL_DUMMY_CYC};
                              end else if (lanes_ff != 3'h0) begin
                                 ph_ff <= PH_RX;
                                 bitc_ff <= sfl_slots(lanes_ff);
                              end else begin
                                 ph_ff <= PH_END;
                              end
                           end else begin
                              cnt_ff <= cnt_ff - 6'h01;
                           end
                        end
                        PH_DUMMY: begin
                           if (cnt_ff == 6'h01) begin
                              ph_ff <= PH_RX;
                              bitc_ff <= sfl_slots(lanes_ff);
                           end else begin
                              cnt_ff <= cnt_ff - 6'h01;
                           end
                        end
                        PH_RX: begin
                           rx_sr_ff <= nxt_rx;
                           if (bitc_ff == 4'h1) begin
                              rd_data_ff <= nxt_rx;
                              rd_valid_ff <= 1'b1;
                              bitc_ff <= sfl_slots(lanes_ff);
                              if (rlen_ff == P_LEN_W'(1)) begin
                                 ph_ff <= PH_END;
                              end else begin
                                 rlen_ff <= rlen_ff - P_LEN_W'(1);
                              end
                           end else begin
                              bitc_ff <= bitc_ff - 4'h1;
                           end
                        end
                        default: sck_ff <= 1'b1;
                     endcase
                  end
               end
            end
         endcase
      end
   end

   // ==============================
   // Outputs
   assign o_cmd_ready = (seq_ff == SQ_IDLE);
   assign o_busy = (seq_ff != SQ_IDLE);
   assign o_rd_valid = rd_valid_ff && (seq_ff == SQ_MAIN);
   assign o_rd_data = rd_data_ff;
   assign o_addr_mode32 = mode32_ff;
   assign o_sck = sck_ff;
   assign o_cs_n = cs_n_ff;
   assign o_io_out = {2'b11, 1'b0, tx_sr_ff[47]};
   assign o_io_oe_n = oe_n_ff;

   // ==============================
   // Checks
   logic [5:0] tx_rises_ff, fop_txn;
   logic [3:0] d_rises_ff;
   sfl_dec_t fop_dec;
   assign fop_dec = sfl_decode(fop_ff);
   assign fop_txn = !fop_dec.has_addr ? (fop_dec.has_wr ? `SFL_TXN_WR : `SFL_TXN_OP)
      : ((mode32_ff || fop_dec.force32) ? `SFL_TXN_A4 : `SFL_TXN_A3);

   always_ff @(posedge i_core_clk) begin
      if (i_rst || ph_ff == PH_IDLE) begin
         tx_rises_ff <= 6'h00;
         d_rises_ff <= 4'h0;
      end else if (hcnt_ff == 8'h00 && !sck_ff && ph_ff != PH_END) begin
         if (ph_ff == PH_TX) begin
            tx_rises_ff <= tx_rises_ff + 6'h01;
         end
         if (ph_ff == PH_DUMMY) begin
            d_rises_ff <= d_rises_ff + 4'h1;
         end
      end
   end

   a_wren_first: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (req_go && fr_op == `SFL_OP_WR_EXT) |-> (fop_ff == `SFL_OP_WREN))
      else $error("upper byte write not preceded by write enable");
   a_addr_width: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (ph_ff == PH_TX) ##1 (ph_ff != PH_TX) |-> (tx_rises_ff == fop_txn))
      else $error("wrong number of opcode and address bits");
   a_dummy_eight: assert property (@(posedge i_core_clk) disable iff (i_rst)
      ($rose(ph_ff == PH_RX) && dummy_ff) |-> (d_rises_ff == `SFL_DUMMY_CYC))
      else $error("dummy cycle count is not eight");
   a_slow_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (ph_ff != PH_IDLE && fop_dec.slow) |-> (half_ff >= 8'(LP_HALF_SLOW)))
      else $error("basic read clock too fast");
   a_lane0_free: assert property (@(posedge i_core_clk) disable iff (i_rst)
      ((ph_ff == PH_RX || ph_ff == PH_DUMMY) && !o_sck) |-> o_io_oe_n[0])
      else $error("lane 0 driven during data output");
   a_quad_free: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (ph_ff != PH_IDLE && lanes_ff == 3'h4 && ph_ff != PH_TX && !o_sck) |-> (o_io_oe_n == 4'hf))
      else $error("host drives a lane in quad read");
   a_enter_wide: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (done_ff && fop_ff == `SFL_OP_EN4) |=> o_addr_mode32)
      else $error("32-bit mode not tracked after enter");
   a_exit_check: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (done_ff && fop_ff == `SFL_OP_EX4) |=> (!o_addr_mode32 && seq_ff == SQ_CHK) ##[1:3] (ph_ff == PH_TX))
      else $error("no readback frame after leaving 32-bit mode");
   a_fix_rewrite: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (done_ff && seq_ff == SQ_CHK && rd_data_ff != ext_user_ff) |=> (seq_ff == SQ_FIX_WE))
      else $error("stale upper byte not rewritten");
   a_nibble_order: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (rd_valid_ff && lanes_ff == 3'h4) |-> (rd_data_ff[3:0] == io_q_ff))
      else $error("quad low nibble misplaced");
endmodule
`default_nettype wire

// File: sfl_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfl_dev_model (
   input wire logic i_rst, // Power-up reset
   input wire logic i_sck, // Serial clock
   input wire logic i_cs_n, // Select, low active
   input wire logic [3:0] i_lane, // Lane levels
   output logic [3:0] o_lane, // Lane values
   output logic [3:0] o_lane_en // Lane enables, high drives
);
   // ====
   // Device state
   logic [7:0] upper_address_byte;
   logic addr_size_flag;
   logic write_latch_flag;
   logic [7:0] op;
   logic [7:0] wd;
   logic [7:0] d;
   logic [31:0] adr;
   logic [31:0] base;
   int nb;
   int hdr;
   int ab;
   int nl;
   int k;

   function automatic logic [7:0] arr_byte(input logic [31:0] a);
      return a[7:0] ^ {a[28:24], a[31:29]} ^ a[15:8] ^ 8'h5a;
   endfunction

   task automatic shape();
      ab = (addr_size_flag || op inside {8'h13, 8'h0c, 8'h3c}) ? 32 : 24;
      hdr = 8 + ab;
      nl = 1;
      case (op)
         8'h03, 8'h13: nl = 1;
         8'h0b, 8'h0c: nl = 1;
         8'h3b, 8'h3c: nl = 2;
         8'h6b: nl = 4;
         8'hc8: hdr = 8;
         default: nl = 0;
      endcase
      if (op inside {8'h0b, 8'h0c, 8'h3b, 8'h3c, 8'h6b}) begin
         hdr = hdr + 8;
      end
   endtask

   // ====
   // Link
   always @(posedge i_rst) begin
      upper_address_byte = 8'h00;
      addr_size_flag = 1'b0;
      write_latch_flag = 1'b0;
      o_lane = 4'h0;
      o_lane_en = 4'h0;
   end

   always @(negedge i_cs_n) begin
      nb = 0;
      op = 8'h00;
      wd = 8'h00;
      adr = 32'h0;
      o_lane_en = 4'h0;
   end

   always @(posedge i_cs_n) begin
      o_lane_en = 4'h0;
      if (nb == 8 && op == 8'h06) begin
         write_latch_flag = 1'b1;
      end
      if (nb == 8 && op == 8'hb7) begin
         addr_size_flag = 1'b1;
      end
      if (nb == 8 && op == 8'he9) begin
         addr_size_flag = 1'b0;
      end
      if (nb == 16 && op == 8'hc5 && write_latch_flag) begin
         upper_address_byte = wd;
      end
   end

   always @(posedge i_sck) begin
      if (!i_cs_n) begin
         shape();
         if (nb < 8) begin
            op = {op[6:0], i_lane[0]};
         end else if (op == 8'hc5 && nb < 16) begin
            wd = {wd[6:0], i_lane[0]};
         end else if (nl != 0 && op != 8'hc8 && nb < 8 + ab) begin
            adr = {adr[30:0], i_lane[0]};
            if (addr_size_flag && nb == 7 + ab) begin
               upper_address_byte = adr[31:24];
            end
         end
         nb = nb + 1;
      end
   end

   always @(negedge i_sck) begin
      if (!i_cs_n && nb >= 8) begin
         shape();
         if (nl != 0 && nb >= hdr) begin // No busy cycle modelled, reads always served
            k = nb - hdr;
            base = (ab == 32) ? adr : {upper_address_byte, adr[23:0]};
            d = (op == 8'hc8) ? upper_address_byte : arr_byte(base + 32'(k / (8 / nl)));
            case (nl)
               1: begin
                  o_lane = {2'b00, d[7 - k % 8], 1'b0};
                  o_lane_en = 4'b0010;
               end
               2: begin
                  o_lane = {2'b00, d[7 - 2 * (k % 4)], d[6 - 2 * (k % 4)]};
                  o_lane_en = 4'b0011;
               end
               default: begin
                  o_lane = (k % 2 == 0) ? d[7:4] : d[3:0];
                  o_lane_en = 4'b1111;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// File: tb_sfl_host.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sfl_host
   import sfl_pkg::*;
;
   logic clk, rst, cv, tgl, idl, ready, busy, rv, m32, sck, cs_n;
   logic [7:0] op_i, wd_i, rd, ext_e, last_c5;
   logic [31:0] addr_i;
   logic [15:0] len_i;
   logic [3:0] io_out, io_oe_n, io_lvl, dev_out, dev_en;
   logic m32_e;
   logic [7:0] rops [7] = '{8'h03, 8'h13, 8'h0b, 8'h0c, 8'h3b, 8'h3c, 8'h6b};
   int n_mismatch, tests_run, r, j;

   sfl_host #(.P_HALF(4), .P_LEN_W(16)) i_sfl_host (
      .i_core_clk(clk), .i_rst(rst), .i_cmd_valid(cv), .i_cmd_opcode(op_i),
      .i_cmd_addr(addr_i), .i_cmd_wdata(wd_i), .i_cmd_len(len_i), .o_cmd_ready(ready),
      .o_busy(busy), .o_rd_valid(rv), .o_rd_data(rd), .o_addr_mode32(m32), .o_sck(sck),
      .o_cs_n(cs_n), .o_io_out(io_out), .o_io_oe_n(io_oe_n), .i_io_in(io_lvl));
   sfl_dev_model i_sfl_dev_model (
      .i_rst(rst), .i_sck(sck), .i_cs_n(cs_n), .i_lane(io_lvl), .o_lane(dev_out), .o_lane_en(dev_en));

   // ====
   // Wire levels, floating lanes wobble
   assign io_lvl = (~io_oe_n & io_out) | (io_oe_n & dev_en & dev_out) | (io_oe_n & ~dev_en & {4{tgl}});
   always @(posedge clk) tgl <= ~tgl;
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   function automatic logic [7:0] exp_byte(input logic [31:0] a);
      return a[7:0] ^ {a[28:24], a[31:29]} ^ a[15:8] ^ 8'h5a;
   endfunction

   task automatic close_out();
      $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      chk8(what, {7'h0, exp}, {7'h0, got});
   endtask

   task automatic issue(input logic [7:0] op, input logic [31:0] a, input logic [7:0] wd, input logic [15:0] len);
      @(posedge clk);
      #1;
      cv = 1'b1;
      op_i = op;
      addr_i = a;
      wd_i = wd;
      len_i = len;
      @(posedge clk);
      #1;
      cv = 1'b0;
   endtask

   task automatic run(input logic [7:0] op, input logic [31:0] a, input logic [7:0] wd, input logic [15:0] len);
      int i;
      int n;
      logic seen;
      logic [31:0] ea;
      n = 0;
      seen = 1'b0;
      ea = (m32_e || op inside {8'h13, 8'h0c, 8'h3c}) ? a : {ext_e, a[23:0]};
      issue(op, a, wd, len);
      for (i = 0; i < 30000; i++) begin
         @(negedge clk);
         if (rv === 1'b1) begin
            chk8("read byte", (op == 8'hc8) ? ext_e : exp_byte(ea + 32'(n)), rd);
            n++;
         end
         seen = seen | (busy === 1'b1);
         if (seen && ready === 1'b1) begin
            break;
         end
      end
      if (i == 30000) begin
         n_mismatch++;
         $display("[ERR] command done expected 1 seen 0");
         close_out();
      end
      chk8("byte count", (op inside {8'h06, 8'hb7, 8'he9, 8'hc5}) ? 8'h0 : ((len == 0) ? 8'h1 : len[7:0]),
           8'(n));
      if (op == 8'hc5) begin
         last_c5 = wd;
         ext_e = wd;
      end
      if (op == 8'hb7) begin
         m32_e = 1'b1;
      end
      if (op == 8'he9) begin
         m32_e = 1'b0;
         ext_e = last_c5;
      end
      if (m32_e && n > 0 && op != 8'hc8) begin
         ext_e = a[31:24];
      end
      chk1("size flag", m32_e, m32);
   endtask

   task automatic do_reset();
      @(posedge clk);
      #1;
      rst = 1'b1;
      repeat (6) @(posedge clk);
      #1;
      rst = 1'b0;
      m32_e = 1'b0;
      ext_e = 8'h00;
      last_c5 = 8'h00;
   endtask

   // ====
   // Main sequence
   initial begin
      r = $urandom(32'h336759b8);
      {rst, cv, op_i, addr_i, wd_i, len_i, tgl} = '0;
      n_mismatch = 0;
      tests_run = 0;
      do_reset();
      chk1("size flag", 1'b0, m32);
      run(8'hc8, 32'h0, 8'h00, 16'h1);
      run(8'hc5, 32'h0, 8'($urandom), 16'h1);
      run(8'hc8, 32'h0, 8'h00, 16'h0);
      for (j = 0; j < 14; j++) begin
         if (j == 7) begin
            run(8'hb7, 32'h0, 8'h00, 16'h1);
         end
         run(rops[j % 7], $urandom, 8'h00, 16'($urandom_range(0, 6)));
         run(8'hc8, 32'h0, 8'h00, 16'h1);
      end
      run(8'he9, 32'h0, 8'h00, 16'h1);
      run(8'hc8, 32'h0, 8'h00, 16'h1);
      run(8'h03, $urandom, 8'h00, 16'h4);
      issue(8'ha5, 32'h0, 8'h00, 16'h1);
      idl = 1'b1;
      repeat (40) begin
         @(negedge clk);
         idl = idl & cs_n & ready;
      end
      chk1("idle after unknown", 1'b1, idl);
      run(8'hb7, 32'h0, 8'h00, 16'h1);
      do_reset();
      chk1("size flag", 1'b0, m32);
      run(8'hc8, 32'h0, 8'h00, 16'h1);
      close_out();
   end
endmodule
`default_nettype wire
